/* logic/tx_cfg_ctrl.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_ctrl import tx_cfg_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // frame request from the mac core
  input wire logic frame_valid,
  input wire logic [10:0] frame_len,
  output logic frame_ready,
  input wire logic speed_100,
  // mii side
  input wire logic mii_crs,
  input wire logic mii_col,
  output logic mii_tx_en,
  output logic mii_rx_en,
  output logic tx_pad,
  // loopback and receive status
  output logic lb_tx_en,
  input wire logic rx_frame_done,
  output logic rx_loopback_flag,
  // frame outcome and interrupt
  output logic tx_done,
  output logic tx_abort,
  output logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tx_state_t st_q, st_d;
  logic [10:0] idx_q, idx_d, wire_len_q, wire_len_d, len_q, len_d;
  logic [6:0] tries_q, tries_d;
  logic [8:0] cnt_q, cnt_d;
  logic hb_seen_q, hb_seen_d, crs_lost_q, crs_lost_d;
  logic mii_tx_en_q, mii_tx_en_d, lb_tx_en_q, lb_tx_en_d;
  logic tx_pad_q, tx_pad_d, done_q, done_d, abort_q, abort_d;
  logic ready_q, ready_d, mii_rx_en_q, mii_rx_en_d;
  logic rx_lb_q, rx_lb_d;
  logic [9:0] tx_stat_q, tx_stat_d;
  logic [IRQ_W-1:0] ev;
  logic [8:0] gap_cyc;
  logic [6:0] try_limit;
  logic csi, heartbeat_disregard, lb, pad_en, retry;
  logic [1:0] gap_trim_field;

  logic [31:0] cfg_q, cfg_d, sqe_q, sqe_d;
  logic [IRQ_W-1:0] isr_q, isr_d, imr_q, imr_d;
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic irq_q, irq_d, wr_fire;

  assign csi = cfg_q[CSI_BIT];
  assign heartbeat_disregard = cfg_q[HBI_BIT];
  assign lb = cfg_q[LB_BIT];
  assign pad_en = cfg_q[PAD_BIT];
  assign retry = cfg_q[RETRY_BIT];
  assign gap_trim_field = cfg_q[GAP_LSB +: 2];
  assign try_limit = retry ? TRIES_EXT : TRIES_STD;
  // trim step is a whole number of cycles at both speeds, so no rounding
  assign gap_cyc = speed_100 ?
    GAP100_CYC - STEP100_CYC * {7'h00, gap_trim_field} :
    GAP10_CYC - STEP10_CYC * {7'h00, gap_trim_field};

  // transmit engine
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    wire_len_d = wire_len_q;
    len_d = len_q;
    tries_d = tries_q;
    cnt_d = cnt_q;
    hb_seen_d = hb_seen_q;
    crs_lost_d = crs_lost_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    tx_stat_d = tx_stat_q;
    ev = '0;
    case (st_q)
      ST_IDLE: begin
        if (frame_valid && ready_q) begin
          len_d = frame_len;
          wire_len_d = (pad_en && frame_len < MIN_FRAME) ?
            MIN_FRAME : frame_len;
          idx_d = '0;
          tries_d = '0;
          crs_lost_d = 1'b0;
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!csi && !mii_crs) crs_lost_d = 1'b1;
        if (mii_col) begin
          // a collision ends this attempt; the retry rides on the gap
          tries_d = tries_q + 7'h01;
          idx_d = '0;
          cnt_d = gap_cyc;
          st_d = ST_GAP;
          if (tries_d == try_limit) begin
            abort_d = 1'b1;
            ev[EV_ABORT] = 1'b1;
            tx_stat_d = {retry ? tries_d[5:4] : 2'b00, tries_d[3:0],
              1'b0, crs_lost_d && !csi, 1'b1, 1'b0};
            tries_d = '0;
          end
        end else if (idx_q + 11'h001 >= wire_len_q) begin
          hb_seen_d = 1'b0;
          cnt_d = HB_WIN_CYC;
          st_d = ST_HB;
        end else begin
          idx_d = idx_q + 11'h001;
        end
      end
      ST_HB: begin
        if (mii_col) hb_seen_d = 1'b1;
        cnt_d = cnt_q - 9'h001;
        if (cnt_q == 9'h001) begin
          done_d = 1'b1;
          ev[EV_DONE] = 1'b1;
          ev[EV_CRS] = crs_lost_q && !csi;
          ev[EV_SQE] = !heartbeat_disregard && !hb_seen_d;
          tx_stat_d = {retry ? tries_q[5:4] : 2'b00, tries_q[3:0],
            ev[EV_SQE], crs_lost_q && !csi, 1'b0, 1'b1};
          // a finished frame must not be sent again after its gap
          tries_d = '0;
          cnt_d = gap_cyc;
          st_d = ST_GAP;
        end
      end
      ST_GAP: begin
        cnt_d = cnt_q - 9'h001;
        if (cnt_q <= 9'h001) begin
          // a frame that collided but has tries left goes out again
          st_d = (tries_q != 7'h00) ? ST_SEND : ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    ready_d = (st_d == ST_IDLE);
    mii_tx_en_d = (st_d == ST_SEND) && !lb;
    lb_tx_en_d = (st_d == ST_SEND) && lb;
    mii_rx_en_d = !lb;
    tx_pad_d = (st_d == ST_SEND) && (idx_d >= len_d);
    rx_lb_d = rx_frame_done ? lb : rx_lb_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      idx_q <= '0;
      wire_len_q <= '0;
      len_q <= '0;
      tries_q <= '0;
      cnt_q <= '0;
      hb_seen_q <= 1'b0;
      crs_lost_q <= 1'b0;
      mii_tx_en_q <= 1'b0;
      lb_tx_en_q <= 1'b0;
      mii_rx_en_q <= 1'b0;
      tx_pad_q <= 1'b0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      ready_q <= 1'b0;
      rx_lb_q <= 1'b0;
      tx_stat_q <= '0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      wire_len_q <= wire_len_d;
      len_q <= len_d;
      tries_q <= tries_d;
      cnt_q <= cnt_d;
      hb_seen_q <= hb_seen_d;
      crs_lost_q <= crs_lost_d;
      mii_tx_en_q <= mii_tx_en_d;
      lb_tx_en_q <= lb_tx_en_d;
      mii_rx_en_q <= mii_rx_en_d;
      tx_pad_q <= tx_pad_d;
      done_q <= done_d;
      abort_q <= abort_d;
      ready_q <= ready_d;
      rx_lb_q <= rx_lb_d;
      tx_stat_q <= tx_stat_d;
    end
  end

  // register slave
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    cfg_d = cfg_q;
    isr_d = isr_q;
    imr_d = imr_q;
    sqe_d = sqe_q;
    if (awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (bvalid_q && bready) bvalid_d = 1'b0;
    wr_fire = aw_full_q && w_full_q && !bvalid_q;
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (aw_addr_q)
        TRANSMIT_CONFIGURATION_OFS: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb_q[i]) cfg_d[8*i +: 8] = w_data_q[8*i +: 8];
          end
          cfg_d[RSV_LSB +: 2] = 2'b00;
        end
        IRQ_STAT_OFS: begin
          if (w_strb_q[0]) isr_d = isr_q & ~w_data_q[IRQ_W-1:0];
        end
        IRQ_MASK_OFS: begin
          if (w_strb_q[0]) imr_d = w_data_q[IRQ_W-1:0];
        end
        TX_STAT_OFS, SQE_CNT_OFS: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    // set after clear, so an event in the clearing cycle survives
    isr_d = isr_d | ev;
    if (ev[EV_SQE]) sqe_d = sqe_q + 32'h00000001;
    if (rvalid_q && rready) rvalid_d = 1'b0;
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (araddr)
        TRANSMIT_CONFIGURATION_OFS: rdata_d = cfg_q;
        IRQ_STAT_OFS: rdata_d = {28'h0000000, isr_q};
        IRQ_MASK_OFS: rdata_d = {28'h0000000, imr_q};
        TX_STAT_OFS: rdata_d = {22'h000000, tx_stat_q};
        SQE_CNT_OFS: rdata_d = sqe_q;
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    arready_d = !rvalid_d;
    irq_d = |(isr_d & imr_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      cfg_q <= TRANSMIT_CONFIGURATION_RST;
      isr_q <= '0;
      imr_q <= '0;
      sqe_q <= '0;
      irq_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      cfg_q <= cfg_d;
      isr_q <= isr_d;
      imr_q <= imr_d;
      sqe_q <= sqe_d;
      irq_q <= irq_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bresp = bresp_q;
  assign bvalid = bvalid_q;
  assign arready = arready_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign rvalid = rvalid_q;
  assign frame_ready = ready_q;
  assign mii_tx_en = mii_tx_en_q;
  assign mii_rx_en = mii_rx_en_q;
  assign tx_pad = tx_pad_q;
  assign lb_tx_en = lb_tx_en_q;
  assign rx_loopback_flag = rx_lb_q;
  assign tx_done = done_q;
  assign tx_abort = abort_q;
  assign irq = irq_q;

  a_reserved_zero: assert property (cfg_q[RSV_LSB +: 2] == 2'b00)
    else $error("reserved bits not zero");
  a_lb_mii_off: assert property (mii_tx_en_q |-> !$past(lb))
    else $error("mii driven in loopback");
  a_lb_rx_off: assert property (lb ##1 lb |-> !mii_rx_en_q)
    else $error("mii rx on in loopback");
  a_rx_lb_flag: assert property (rx_frame_done |=>
    rx_loopback_flag == $past(lb)) else $error("rx loopback flag wrong");
  a_pad_needs_en: assert property ($rose(st_q == ST_SEND) &&
    $past(!pad_en) |-> wire_len_q == len_q) else $error("padding while off");
  a_pad_min_len: assert property ($rose(st_q == ST_SEND) &&
    $past(pad_en) |-> wire_len_q >= MIN_FRAME) else $error("runt not padded");
  a_abort_std: assert property (abort_q && $past(!retry) |->
    $past(tries_q) == 7'h0f) else $error("abort not at attempt 16");
  a_abort_ext: assert property (abort_q && $past(retry) |->
    $past(tries_q) == 7'h3f) else $error("abort not at attempt 64");
  a_sqe_count: assert property (done_q && $past(heartbeat_disregard) |->
    sqe_q == $past(sqe_q)) else $error("sqe counted while ignored");
  a_crs_ignored: assert property ((done_q || abort_q) && $past(csi) |->
    !tx_stat_q[2]) else $error("carrier reported while ignored");
  a_gap_load: assert property (st_q == ST_HB && st_d == ST_GAP |=>
    cnt_q == $past(gap_cyc)) else $error("gap length wrong");
endmodule
`default_nettype wire

/* logic/tx_cfg_pkg.sv */
// What this block does
// - with carrier ignore set, carrier activity is disregarded and no carrier loss is reported.
// - with carrier ignore clear, carrier is watched during each send and loss is reported in the transmit status and, for a completed frame, the interrupt status.
// - with heartbeat ignore set, the post-frame heartbeat is ignored and no sqe error is counted.
// - with heartbeat ignore clear, a missing heartbeat after a frame bumps the sqe error counter.
// - loopback routes transmit frames to the receive path and turns off both mii directions.
// - every frame received during loopback carries the loopback flag in its status.
// - with auto padding on, frames shorter than 64 bytes are padded out to 64 bytes.
// - with auto padding off, short frames go out unpadded and software pads them.
// - at 10 Mb/s the gap is 9.6 us minus 0.4 us times the gap trim field.
// - at 100 Mb/s the gap is 960 ns minus 40 ns times the gap trim field.
// - the two reserved bits ignore writes and read as zero.
// - with excess retry on, a frame gets up to 64 attempts and aborts when attempt 64 fails.
// - with excess retry off, a frame aborts after its 16th failed attempt.
// - excess retry changes how collisions are reported in the transmit status.
package tx_cfg_pkg;
  localparam logic [7:0] TRANSMIT_CONFIGURATION_OFS = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h44;
  localparam logic [7:0] TX_STAT_OFS = 8'h48;
  localparam logic [7:0] SQE_CNT_OFS = 8'h4c;
  localparam logic [31:0] TRANSMIT_CONFIGURATION_RST = 32'h00000102;
  localparam int CSI_BIT = 31;
  localparam int HBI_BIT = 30;
  localparam int LB_BIT = 29;
  localparam int PAD_BIT = 28;
  localparam int GAP_LSB = 26;
  localparam int RSV_LSB = 24;
  localparam int RETRY_BIT = 23;
  localparam int IRQ_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_CRS = 2;
  localparam int EV_SQE = 3;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [6:0] TRIES_STD = 7'h10;
  localparam logic [6:0] TRIES_EXT = 7'h40;
  localparam int CLK_NS = 20;
  localparam int GAP10_NS = 9600;
  localparam int STEP10_NS = 400;
  localparam int GAP100_NS = 960;
  localparam int STEP100_NS = 40;
  localparam int HB_WIN_NS = 1600;
  localparam logic [8:0] GAP10_CYC = 9'((GAP10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] STEP10_CYC = 9'(STEP10_NS / CLK_NS);
  localparam logic [8:0] GAP100_CYC = 9'((GAP100_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [8:0] STEP100_CYC = 9'(STEP100_NS / CLK_NS);
  localparam logic [8:0] HB_WIN_CYC = 9'(HB_WIN_NS / CLK_NS);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_HB = 2'b11,
    ST_GAP = 2'b10
  } tx_state_t;
endpackage

/* testbench/phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  // clock and bench controls
  input wire logic aclk,
  input wire logic clr,
  input wire logic hb_en,
  input wire logic drop_crs,
  input wire logic [6:0] coll_n,
  // mii
  input wire logic mii_tx_en,
  output logic mii_crs,
  output logic mii_col,
  output logic [6:0] att
);
  logic prev_q;
  logic [3:0] hb_q;
  initial begin
    mii_col = 1'b0;
    att = 7'h00;
    prev_q = 1'b0;
    hb_q = 4'h0;
  end
  // carrier follows our own send, so a staged loss covers whole frame
  assign mii_crs = mii_tx_en & ~drop_crs;
  always @(posedge aclk) begin
    prev_q <= mii_tx_en;
    hb_q <= (prev_q & ~mii_tx_en) ? 4'h5 : (hb_q != 4'h0 ? hb_q - 4'h1 : 4'h0);
    // collide in each attempt until coll_n attempts failed, then heartbeat
    mii_col <= (mii_tx_en & (att < coll_n)) |
      (hb_en & hb_q == 4'h1);
    if (clr) begin
      att <= 7'h00;
    end else if (prev_q & ~mii_tx_en) begin
      att <= att + 7'h01;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top import tx_cfg_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic frame_valid, speed_100, rx_frame_done, clr, hb_en, drop_crs;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got, sqe0;
  logic [3:0] wstrb;
  logic [10:0] frame_len;
  logic awready, wready, bvalid, arready, rvalid, frame_ready, irq;
  logic mii_crs, mii_col, mii_tx_en, mii_rx_en, tx_pad, lb_tx_en;
  logic rx_loopback_flag, tx_done, tx_abort, ended_abort;
  logic [1:0] bresp, rresp, resp;
  logic [6:0] coll_n, att;
  int fails, total_checks, n_tx, n_pad, n_lb, gap_n, g0;

  tx_cfg_ctrl uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .frame_valid, .frame_len,
    .frame_ready, .speed_100, .mii_crs, .mii_col, .mii_tx_en, .mii_rx_en,
    .tx_pad, .lb_tx_en, .rx_frame_done, .rx_loopback_flag, .tx_done,
    .tx_abort, .irq);
  phy_model phy (.aclk, .clr, .hb_en, .drop_crs, .coll_n, .mii_tx_en,
    .mii_crs, .mii_col, .att);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_left, w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // local flags: the valid regs only change in the nba region
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // one frame; counts wire cycles, pad cycles and the following gap
  task automatic frame(input logic [10:0] l);
    n_tx = 0;
    n_pad = 0;
    n_lb = 0;
    gap_n = 0;
    clr <= 1'b1;
    do @(posedge aclk); while (frame_ready !== 1'b1);
    clr <= 1'b0;
    frame_valid <= 1'b1;
    frame_len <= l;
    @(posedge aclk);
    frame_valid <= 1'b0;
    while (tx_done !== 1'b1 && tx_abort !== 1'b1) begin
      @(posedge aclk);
      n_tx += int'(mii_tx_en);
      n_pad += int'(tx_pad);
      n_lb += int'(lb_tx_en);
    end
    ended_abort = tx_abort;
    while (frame_ready !== 1'b1) begin
      @(posedge aclk);
      gap_n++;
    end
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, frame_valid} = 6'h00;
    {rx_frame_done, clr, drop_crs, hb_en, speed_100} = 5'h03;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    frame_len = 11'h000;
    coll_n = 7'h00;
    fails = 0;
    total_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(TRANSMIT_CONFIGURATION_OFS);
    `CHK(got, TRANSMIT_CONFIGURATION_RST)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'hffffffff);
    `CHK(resp, RESP_OKAY)
    rd(TRANSMIT_CONFIGURATION_OFS);
    `CHK(got, 32'hfcffffff)
    rd(8'h80);
    `CHK(resp, RESP_SLVERR)
    wr(8'h80, 32'h00000000);
    `CHK(resp, RESP_SLVERR)
    wr(IRQ_MASK_OFS, 32'h0000000f);
    rd(SQE_CNT_OFS);
    sqe0 = got;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h50000000);
    frame(11'h00a);
    `CHK(n_tx, 64)
    `CHK(n_pad, 54)
    `CHK(irq, 1'b1)
    wr(IRQ_STAT_OFS, 32'h0000000f);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40000000);
    frame(11'h00a);
    `CHK(n_tx, 10)
    `CHK(n_pad, 0)
    g0 = gap_n;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h4c000000);
    frame(11'h00a);
    `CHK(g0 - gap_n, 6)
    speed_100 <= 1'b0;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40000000);
    frame(11'h00a);
    g0 = gap_n;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h4c000000);
    frame(11'h00a);
    `CHK(g0 - gap_n, 60)
    speed_100 <= 1'b1;
    // heartbeat withheld by the far side
    hb_en <= 1'b0;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h00000000);
    frame(11'h040);
    rd(SQE_CNT_OFS);
    `CHK(got, sqe0 + 32'h1)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40000000);
    frame(11'h040);
    rd(SQE_CNT_OFS);
    `CHK(got, sqe0 + 32'h1)
    hb_en <= 1'b1;
    drop_crs <= 1'b1;
    frame(11'h040);
    rd(TX_STAT_OFS);
    `CHK(got[2], 1'b1)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'hc0000000);
    frame(11'h040);
    rd(TX_STAT_OFS);
    `CHK(got[2], 1'b0)
    drop_crs <= 1'b0;
    coll_n <= 7'h7f;
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40000000);
    frame(11'h00a);
    `CHK(ended_abort, 1'b1)
    `CHK(att, 7'h10)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40800000);
    frame(11'h00a);
    `CHK(att, 7'h40)
    coll_n <= 7'h14;
    frame(11'h00a);
    `CHK(ended_abort, 1'b0)
    rd(TX_STAT_OFS);
    `CHK(got[9:8], 2'b01)
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h40000000);
    frame(11'h00a);
    rd(TX_STAT_OFS);
    `CHK(got[9:8], 2'b00)
    coll_n <= 7'h00;
    // transmitter is idle here, as loopback entry needs
    wr(TRANSMIT_CONFIGURATION_OFS, 32'h60000000);
    repeat (2) @(posedge aclk);
    `CHK(mii_rx_en, 1'b0)
    frame(11'h046);
    `CHK(n_tx, 0)
    `CHK(n_lb, 70)
    rx_frame_done <= 1'b1;
    @(posedge aclk);
    rx_frame_done <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(rx_loopback_flag, 1'b1)
    tally_and_finish;
  end
endmodule
`default_nettype wire
